// [common/csp_consts.svh]
// Constants for the codec control serial port: layout, register fields and timing
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// Frame layout: {read flag, 3 spare, reg_addr_field[3:0], reg_data_field[7:0]}
`define CSP_REG_COUNT 16
`define CSP_BYTE_BITS 8
`define CSP_FRAME_BITS 16
`define CSP_READ_BIT 7
`define CSP_ADDR_BITS 4
`define CSP_REG_RESET 8'h00

// Byte registers and bits that steer logic outside the port
`define CSP_REG_CFG_ZERO 4'h0
`define CSP_REG_CFG_TWO 4'h2
`define CSP_CFG0_EXT_SEQ_BIT 7
`define CSP_CFG0_PUMP_EN_BIT 2
`define CSP_CFG2_HALF_SUPPLY_BIT 7

// Timing: host clock rate limit and the analog sequencing clock divider
`define CSP_SYS_CLK_HZ 100000000
`define CSP_CLK_MAX_HZ 4096000
`define CSP_CLK_PERIOD_CYC ((`CSP_SYS_CLK_HZ + `CSP_CLK_MAX_HZ - 1) / `CSP_CLK_MAX_HZ)
`define CSP_HALF_CYC ((`CSP_CLK_PERIOD_CYC + 1) / 2)
`define CSP_MCLK_HZ 20480000
`define CSP_SEQ_HZ 256000
`define CSP_SEQ_DIV (`CSP_MCLK_HZ / `CSP_SEQ_HZ)

`endif

// [common/csp_if.sv]
// Four-wire control serial port between the host and the codec
interface csp_if;
  logic port_select_n;
  logic ctrl_port_clock;
  logic ctrl_serial_in;
  logic ctrl_serial_out;

  modport dev (
    input port_select_n,
    input ctrl_port_clock,
    input ctrl_serial_in,
    output ctrl_serial_out
  );

  modport host (
    output port_select_n,
    output ctrl_port_clock,
    output ctrl_serial_in,
    input ctrl_serial_out
  );
endinterface

// [common/csp_pkg.sv]
// Types for the host end of the codec control serial port
package csp_pkg;

  // Host sequencer states, Gray coded along idle-lead-shift-tail-gap
  typedef enum logic [2:0] {
    CSP_IDLE  = 3'b000,
    CSP_LEAD  = 3'b001,
    CSP_SHIFT = 3'b011,
    CSP_TAIL  = 3'b010,
    CSP_GAP   = 3'b110
  } csp_host_state_e;

  typedef logic [7:0] csp_byte_t;

endpackage

// [src/csp_device.sv]
// Codec end of the control serial port with its byte registers and power control
//
// What this block does
// RULE1: Exchange data only while select is low.
// RULE2: Host holds select for sixteen clock periods. A split access holds it for eight periods per select.
// RULE3: Sample serial input on rising clock edges.
// RULE4: Change output on falling edges, MSB first.
// RULE5: Static logic, clock from stopped to 4.096 MHz.
// RULE6: Ignore clock edges while select is high.
// RULE7: Ignore input when deselected or sending read data.
// RULE8: Sixteen eight-bit byte registers, zero to fifteen.
// RULE9: Two-byte form: address byte, then data byte.
// RULE10: One 16-bit frame carries address and data.
// RULE11: Full duplex over four signals, one clock.
// RULE12: Power-down input low holds low-power mode.
// RULE13: Power-down rising edge restores power, resets transcoder.
// RULE14: Config zero bit 7 picks external sequencing clock.
// RULE15: Config two bit 7 picks output DC reference.
// RULE16: Divide master clock down to 256 kHz.
// RULE17: Config zero bit 2 enables the charge pump.
// RULE18: Short frames are discarded, counter restarts next select. An eight-bit frame is kept as an address byte.
// RULE19: First byte carries a read flag beside address.
`include "csp_consts.svh"

module csp_device (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Control serial port
  csp_if.dev link,
  // Power and clock inputs from the board
  input wire logic powerdown_reset_in_i,
  input wire logic dsp_master_clock_i,
  input wire logic receive_bit_clock_i,
  // Control outputs to the analog and transcoder sections
  output logic low_power_o,
  output logic transcoder_reset_o,
  output logic seq_tick_o,
  output logic ext_seq_clk_sel_o,
  output logic half_supply_ref_o,
  output logic charge_pump_en_o
);

  localparam int SeqDiv = `CSP_SEQ_DIV;

  logic sclk_q;
  logic sel_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  logic [4:0] bit_cnt_q;
  logic [7:0] first_q;
  logic [7:0] data_q;
  logic pend_q;
  logic [7:0] pend_byte_q;
  logic [7:0] tx_shift_q;
  logic tx_q;
  logic [7:0] regs_q [`CSP_REG_COUNT];
  logic [7:0] cmd;
  logic is_read;
  logic [3:0] addr;
  logic pdn_q;
  logic mclk_q;
  logic rbclk_q;
  logic [6:0] div_q;
  logic int_tick_q;

  // Pins are synchronous to sys_clk, so one stage is enough to find edges
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      sclk_q <= 1'b0;
      sel_q <= 1'b0;
    end
    else
    begin
      sclk_q <= link.ctrl_port_clock;
      sel_q <= ~link.port_select_n;
    end
  end

  // Edges only count while selected; a free-running clock is harmless [RULE6] [RULE5]
  assign sclk_rise = ~link.port_select_n & link.ctrl_port_clock & ~sclk_q; // [RULE3] [RULE1]
  assign sclk_fall = ~link.port_select_n & ~link.ctrl_port_clock & sclk_q; // [RULE4]
  assign sel_fall = ~link.port_select_n & ~sel_q;
  assign sel_rise = link.port_select_n & sel_q;

  // The command byte is the live one, or the one kept from a split transfer
  assign cmd = pend_q ? pend_byte_q : first_q; // [RULE9]
  assign is_read = cmd[`CSP_READ_BIT]; // [RULE19]
  assign addr = cmd[`CSP_ADDR_BITS-1:0];

  // Bit counter: restarts at each select, resumes at eight after an address byte
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      bit_cnt_q <= 5'h00;
    else if (sel_fall)
      bit_cnt_q <= pend_q ? 5'h08 : 5'h00; // [RULE18] [RULE9]
    else if (sclk_rise && bit_cnt_q != 5'h10)
      bit_cnt_q <= bit_cnt_q + 5'h01; // [RULE2]
  end

  // Input shifter; read data phase and deselect leave it untouched [RULE7]
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      first_q <= 8'h00;
      data_q <= 8'h00;
    end
    else if (sclk_rise && bit_cnt_q < 5'h08)
      first_q <= {first_q[6:0], link.ctrl_serial_in}; // [RULE3]
    else if (sclk_rise && bit_cnt_q < 5'h10 && !is_read)
      data_q <= {data_q[6:0], link.ctrl_serial_in}; // [RULE10]
  end

  // Split transfer: a select that ends after exactly eight bits keeps the address
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pend_q <= 1'b0;
      pend_byte_q <= 8'h00;
    end
    else if (sel_rise)
    begin
      pend_q <= (bit_cnt_q == 5'h08) && !pend_q; // [RULE9] [RULE18]
      pend_byte_q <= first_q;
    end
  end

  // Register file; a write lands only when the full sixteenth bit arrives
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < `CSP_REG_COUNT; i++)
        regs_q[i] <= `CSP_REG_RESET; // [RULE8]
    end
    else if (sclk_rise && bit_cnt_q == 5'h0F && !is_read)
      regs_q[addr] <= {data_q[6:0], link.ctrl_serial_in}; // [RULE8] [RULE18]
  end

  // Read data: loaded at the address boundary, moved out on falling edges
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      tx_shift_q <= 8'h00;
      tx_q <= 1'b0;
    end
    else if (sel_fall && pend_q && pend_byte_q[`CSP_READ_BIT])
    begin
      // Second select of a split read: first bit must be up before any rising edge
      tx_q <= regs_q[pend_byte_q[`CSP_ADDR_BITS-1:0]][7]; // [RULE4]
      tx_shift_q <= {regs_q[pend_byte_q[`CSP_ADDR_BITS-1:0]][6:0], 1'b0};
    end
    else if (sclk_rise && bit_cnt_q == 5'h07 && first_q[6])
      tx_shift_q <= regs_q[{first_q[2:0], link.ctrl_serial_in}]; // [RULE10] [RULE19]
    else if (sclk_fall && bit_cnt_q >= 5'h08 && is_read)
    begin
      tx_q <= tx_shift_q[7]; // [RULE4] [RULE11]
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
    else if (link.port_select_n)
      tx_q <= 1'b0; // [RULE1]
  end

  assign link.ctrl_serial_out = tx_q;

  // Power-down level and the rising edge that resets the transcoder
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pdn_q <= 1'b0;
      low_power_o <= 1'b1;
      transcoder_reset_o <= 1'b0;
    end
    else
    begin
      pdn_q <= powerdown_reset_in_i;
      low_power_o <= ~powerdown_reset_in_i; // [RULE12]
      transcoder_reset_o <= powerdown_reset_in_i & ~pdn_q; // [RULE13]
    end
  end

  // Master clock divider; an off-multiple master clock drifts, not breaks
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      mclk_q <= 1'b0;
      rbclk_q <= 1'b0;
      div_q <= 7'h00;
      int_tick_q <= 1'b0;
    end
    else
    begin
      mclk_q <= dsp_master_clock_i;
      rbclk_q <= receive_bit_clock_i;
      int_tick_q <= 1'b0;
      if (dsp_master_clock_i && !mclk_q)
      begin
        if (div_q == 7'(SeqDiv - 1))
        begin
          div_q <= 7'h00;
          int_tick_q <= 1'b1; // [RULE16]
        end
        else
          div_q <= div_q + 7'h01;
      end
    end
  end

  // Sequencing tick source and the static configuration outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      seq_tick_o <= 1'b0;
    else if (regs_q[`CSP_REG_CFG_ZERO][`CSP_CFG0_EXT_SEQ_BIT])
      seq_tick_o <= receive_bit_clock_i & ~rbclk_q; // [RULE14]
    else
      seq_tick_o <= int_tick_q; // [RULE16]
  end

  assign ext_seq_clk_sel_o = regs_q[`CSP_REG_CFG_ZERO][`CSP_CFG0_EXT_SEQ_BIT]; // [RULE14]
  assign half_supply_ref_o = regs_q[`CSP_REG_CFG_TWO][`CSP_CFG2_HALF_SUPPLY_BIT]; // [RULE15]
  assign charge_pump_en_o = regs_q[`CSP_REG_CFG_ZERO][`CSP_CFG0_PUMP_EN_BIT]; // [RULE17]

endmodule // csp_device

// [src/csp_host.sv]
// Host end of the control serial port: runs one register access per request
`include "csp_consts.svh"

module csp_host (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Control serial port
  csp_if.host link,
  // Request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_read_i,
  input wire logic req_split_i,
  input wire logic [3:0] req_addr_i,
  input wire logic [7:0] req_data_i,
  // Answer
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o
);

  localparam int HalfCyc = `CSP_HALF_CYC;

  csp_pkg::csp_host_state_e state_q;
  logic [4:0] timer_q;
  logic tick;
  logic accept;
  logic rejoin;
  logic sclk_q;
  logic sel_n_q;
  logic [15:0] shift_q;
  logic [4:0] bit_q;
  logic [4:0] frame_len;
  logic frame_done;
  logic split_q;
  logic second_q;
  logic read_q;
  logic [7:0] rx_q;

  // Every clock phase lasts a full timer lap, which keeps the rate under the limit [RULE5]
  assign tick = timer_q == 5'(HalfCyc - 1);
  assign accept = (state_q == csp_pkg::CSP_IDLE) && req_valid_i;
  assign rejoin = (state_q == csp_pkg::CSP_GAP) && tick && split_q && !second_q; // [RULE9]
  assign req_ready_o = state_q == csp_pkg::CSP_IDLE;

  // A split access sends eight bits per select, a single one sixteen [RULE2] [RULE10]
  assign frame_len = split_q ? 5'h08 : 5'h10;
  assign frame_done = bit_q == frame_len;

  // Half-period timer, idle while waiting for a request
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || state_q == csp_pkg::CSP_IDLE || tick)
      timer_q <= 5'h00;
    else
      timer_q <= timer_q + 5'h01;
  end

  // Sequencer: lead-in, shifting, tail, then a gap before the next select
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      state_q <= csp_pkg::CSP_IDLE;
    else
    begin
      case (state_q)
        csp_pkg::CSP_IDLE:
          if (req_valid_i)
            state_q <= csp_pkg::CSP_LEAD;
        csp_pkg::CSP_LEAD:
          if (tick)
            state_q <= csp_pkg::CSP_SHIFT;
        csp_pkg::CSP_SHIFT:
          if (tick && sclk_q && frame_done)
            state_q <= csp_pkg::CSP_TAIL;
        csp_pkg::CSP_TAIL:
          if (tick)
            state_q <= csp_pkg::CSP_GAP;
        csp_pkg::CSP_GAP:
          if (rejoin)
            state_q <= csp_pkg::CSP_LEAD;
          else if (tick)
            state_q <= csp_pkg::CSP_IDLE;
        default:
          state_q <= csp_pkg::CSP_IDLE;
      endcase
    end
  end

  // Port clock rests low outside frames and toggles only while shifting [RULE6]
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      sclk_q <= 1'b0;
    else if (state_q == csp_pkg::CSP_SHIFT && tick)
      sclk_q <= ~sclk_q;
  end

  // Select falls with the clock low and rises only after the last falling edge [RULE1]
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      sel_n_q <= 1'b1;
    else if (accept || rejoin)
      sel_n_q <= 1'b0;
    else if (state_q == csp_pkg::CSP_TAIL && tick)
      sel_n_q <= 1'b1;
  end

  // Access kind, kept for both halves of a split transfer
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      split_q <= 1'b0;
      read_q <= 1'b0;
      second_q <= 1'b0;
    end
    else if (accept)
    begin
      split_q <= req_split_i;
      read_q <= req_read_i;
      second_q <= 1'b0;
    end
    else if (rejoin)
      second_q <= 1'b1;
  end

  // Outgoing word: read flag, spare bits, address, data; moves on falling edges [RULE19]
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      shift_q <= 16'h0000;
    else if (accept)
      shift_q <= {req_read_i, 3'b000, req_addr_i, req_data_i};
    else if (state_q == csp_pkg::CSP_SHIFT && tick && sclk_q)
      shift_q <= {shift_q[14:0], 1'b0};
  end

  // Rising edges in the current select
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || accept || rejoin)
      bit_q <= 5'h00;
    else if (state_q == csp_pkg::CSP_SHIFT && tick && !sclk_q)
      bit_q <= bit_q + 5'h01;
  end

  // Read data taken as the clock rises; the last eight bits are the register [RULE11]
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rx_q <= 8'h00;
    else if (state_q == csp_pkg::CSP_SHIFT && tick && !sclk_q)
      rx_q <= {rx_q[6:0], link.ctrl_serial_out};
  end

  // Answer stands until the next request is taken
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || accept)
      rsp_valid_o <= 1'b0;
    else if (state_q == csp_pkg::CSP_GAP && tick && !rejoin)
      rsp_valid_o <= read_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rsp_data_o <= 8'h00;
    else if (state_q == csp_pkg::CSP_GAP && tick && !rejoin)
      rsp_data_o <= rx_q;
  end

  assign link.port_select_n = sel_n_q;
  assign link.ctrl_port_clock = sclk_q;
  assign link.ctrl_serial_in = shift_q[15]; // [RULE4]

endmodule // csp_host

// [verif/csp_checker.sv]
// Wire checks on the control serial port between host and codec ends
`include "csp_consts.svh"
module csp_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Link wires
  input wire logic port_select_n,
  input wire logic ctrl_port_clock,
  input wire logic ctrl_serial_in,
  input wire logic ctrl_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MAXF = 1000;
  logic [4:0] rise_q;
  logic [7:0] gap_q;
  logic half_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Rising clock edges in the current frame
  always_ff @(posedge sys_clk_i)
    if (reset_i || port_select_n) rise_q <= 5'h00;
    else if ($rose(ctrl_port_clock)) rise_q <= rise_q + 5'h01;
  // Cycles since the last rise; saturates so long idles stay legal
  always_ff @(posedge sys_clk_i)
    if (reset_i || $rose(ctrl_port_clock)) gap_q <= 8'h01;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  // Set between the two eight-bit selects of a split access
  always_ff @(posedge sys_clk_i)
    if (reset_i) half_q <= 1'b0;
    else if ($rose(port_select_n)) half_q <= (rise_q == 5'h08) && !half_q;
  chk_out_on_fall: assert property (
    !port_select_n && !$past(port_select_n) && $changed(ctrl_serial_out) |-> !ctrl_port_clock)
    else $error("serial out moved while clock high");
  chk_in_held_rise: assert property (
    $rose(ctrl_port_clock) && !port_select_n |-> $stable(ctrl_serial_in) [*3])
    else $error("serial in moved at sampling edge");
  chk_clk_rate_max: assert property (
    $rose(ctrl_port_clock) && rise_q != 5'h00 |-> gap_q >= `CSP_CLK_PERIOD_CYC)
    else $error("port clock too fast");
  chk_frame_len: assert property (
    $rose(port_select_n) |-> (rise_q == 5'h10 && !half_q) || rise_q == 5'h08)
    else $error("frame not sixteen periods");
  chk_frame_max: assert property (
    !port_select_n |-> rise_q <= 5'h10)
    else $error("frame exceeds sixteen periods");
  chk_frame_bound: assert property (
    $fell(port_select_n) |-> ##[1:MAXF] $rose(port_select_n))
    else $error("select held low too long");
  chk_sel_open: assert property (
    $fell(port_select_n) |-> $stable(ctrl_port_clock))
    else $error("clock moved with select fall");
  chk_quiet_idle: assert property (
    port_select_n [*3] |=> $stable(ctrl_serial_out))
    else $error("serial out moved while deselected");
endmodule // csp_checker

// [verif/tb_codec_serial_control_port.sv]
// Bench joining host and codec ends; register traffic with expected values
`include "csp_consts.svh"
module tb_codec_serial_control_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic powerdown_reset_in_i = 1'b0;
  logic dsp_master_clock_i = 1'b0;
  logic receive_bit_clock_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_read_i = 1'b0;
  logic req_split_i = 1'b0;
  logic [3:0] req_addr_i = 4'h0;
  logic [7:0] req_data_i = 8'h00;
  logic req_ready_o, rsp_valid_o, low_power_o, transcoder_reset_o, seq_tick_o;
  logic ext_seq_clk_sel_o, half_supply_ref_o, charge_pump_en_o;
  logic [7:0] rsp_data_o;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  time t0;
  localparam int MclkHalfNs = 24;
  csp_if link_if ();
  csp_host i_csp_host (.sys_clk_i, .reset_i, .link(link_if.host), .req_valid_i,
    .req_ready_o, .req_read_i, .req_split_i, .req_addr_i, .req_data_i, .rsp_valid_o,
    .rsp_data_o);
  csp_device i_csp_device (.sys_clk_i, .reset_i, .link(link_if.dev), .powerdown_reset_in_i,
    .dsp_master_clock_i, .receive_bit_clock_i, .low_power_o, .transcoder_reset_o,
    .seq_tick_o, .ext_seq_clk_sel_o, .half_supply_ref_o, .charge_pump_en_o);
  csp_checker i_csp_checker (.sys_clk_i, .reset_i, .port_select_n(link_if.port_select_n),
    .ctrl_port_clock(link_if.ctrl_port_clock), .ctrl_serial_in(link_if.ctrl_serial_in),
    .ctrl_serial_out(link_if.ctrl_serial_out));
  // System clock and a master clock inside the allowed band
  always #5 sys_clk_i = ~sys_clk_i;
  always #MclkHalfNs dsp_master_clock_i = ~dsp_master_clock_i;
  // Hang guard, far above the few hundred cycles each access needs
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait on falling edges; a flag that never arrives is a mismatch
  task automatic wait_lvl(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 3000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({7'h00, sig}, {7'h00, lvl});
  endtask
  // One register access; request held until ready is seen at a rising edge
  task automatic access(input logic rd, input logic sp, input logic [3:0] a,
    input logic [7:0] d);
    req_valid_i = 1'b1;
    req_read_i = rd;
    req_split_i = sp;
    req_addr_i = a;
    req_data_i = d;
    @(posedge sys_clk_i);
    while (req_ready_o !== 1'b1) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    wait_lvl(link_if.port_select_n, 1'b0);
    wait_lvl(link_if.port_select_n, 1'b1);
    if (sp)
    begin
      wait_lvl(link_if.port_select_n, 1'b0);
      wait_lvl(link_if.port_select_n, 1'b1);
    end
    if (rd)
    begin
      wait_lvl(rsp_valid_o, 1'b1);
      chk(rsp_data_o, d);
    end
    repeat (4) @(negedge sys_clk_i);
  endtask
  // Main sequence: power control, every register both forms, config bits
  initial
  begin
    repeat (20) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk({7'h00, low_power_o}, 8'h01);
    powerdown_reset_in_i = 1'b1;
    wait_lvl(transcoder_reset_o, 1'b1);
    repeat (50) @(negedge sys_clk_i);
    chk({7'h00, low_power_o}, 8'h00);
    for (int i = 0; i < 16; i++)
      access(1'b0, i[0], i[3:0], 8'h5A ^ 8'(i * 17));
    for (int i = 0; i < 16; i++)
      access(1'b1, ~i[0], i[3:0], 8'h5A ^ 8'(i * 17));
    access(1'b0, 1'b0, 4'h0, 8'h84);
    chk({6'h00, ext_seq_clk_sel_o, charge_pump_en_o}, 8'h03);
    access(1'b0, 1'b1, 4'h0, 8'h7B);
    chk({6'h00, ext_seq_clk_sel_o, charge_pump_en_o}, 8'h00);
    access(1'b0, 1'b1, 4'h2, 8'h80);
    chk({7'h00, half_supply_ref_o}, 8'h01);
    access(1'b0, 1'b0, 4'h2, 8'h7F);
    chk({7'h00, half_supply_ref_o}, 8'h00);
    // Internal tick spacing: one tick per divider count of master periods
    wait_lvl(seq_tick_o, 1'b1);
    t0 = $time;
    @(negedge sys_clk_i);
    wait_lvl(seq_tick_o, 1'b1);
    chk(16'(($time - t0) / 10), 16'(`CSP_SEQ_DIV * 2 * MclkHalfNs / 10));
    give_verdict();
  end
endmodule // tb_codec_serial_control_port
